// ### core/ccs_core.sv
/*
  Clock-synchronous serial transfer channel with an APB register slave.
  Assumes all pin inputs and source ticks are synchronous to clock_in.
*/
// Our own choices: the placing of the registers and the APB interface to the registers.
// Summary of operation
// - One transfer moves exactly eight bits.
// - Master divides selected source by sixteen.
// - Slave uses external shift clock directly.
// - Half duplex only, never both directions.
// - Bit order selects LSB or MSB first.
// - Mode 00 master, mode 01 slave.
// - Parity setting ignored in synchronous mode.
// - Pins are general ports until enabled.
// - Transmit trigger starts clock or awaits master.
// - Output bit shifts on falling edge.
// - Output holds last bit until next send.
// - Sent word sets transmit done flag.
// - Receive trigger starts clock or awaits master, samples rising.
// - Eighth rising edge buffers byte, sets flag.
// - Slave ready low when ready, high busy.
// - Ready falls on trigger, rises first fall.
// - Master mode leaves ready pin general.
// - Trigger reads one while operation runs.
`timescale 1ns/1ps
module ccs_core (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [3:0] clk_src_tick_in,
  input wire logic [3:0] pins_in,
  input wire ccs_pkg::ccs_pins_t port_in,
  output ccs_pkg::ccs_pins_t pins_out
);
  ccs_pkg::ccs_state_t state_ff;
  ccs_pkg::ccs_state_t nxt_state;
  logic is_master;
  logic is_slave;
  logic sync_ok;
  logic tick;
  logic fall;
  logic rise;
  logic start_tx;
  logic start_rx;
  logic wr_acc;
  logic rd_setup;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic out_bit;

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  // Read data is captured in the setup cycle, so every access ends in one cycle.
  // Unmapped offsets raise the error response and read back as zero.
  assign pready_out = 1'b1;
  assign wr_acc = psel_in & penable_in & pwrite_in;
  assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
  assign pslverr_out = psel_in & penable_in & (paddr_in != ccs_pkg::CCS_OFF_CTRL)
    & (paddr_in != ccs_pkg::CCS_OFF_TRIG) & (paddr_in != ccs_pkg::CCS_OFF_DATA);
  assign prdata_out = state_ff.prdata;

  // ----------------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    is_master = state_ff.mode == ccs_pkg::CCS_MODE_MASTER;
    is_slave = state_ff.mode == ccs_pkg::CCS_MODE_SLAVE;
    sync_ok = state_ff.pin_en & (is_master | is_slave);
    tick = clk_src_tick_in[state_ff.clk_src];
    fall = 1'b0;
    rise = 1'b0;
    start_tx = 1'b0;
    start_rx = 1'b0;
    // Parity enable is stored for software only; nothing here reads it.
    out_bit = state_ff.order ? state_ff.shreg[7] : state_ff.shreg[0];
    tx_shift = state_ff.order ? {state_ff.shreg[6:0], 1'b0} : {1'b0, state_ff.shreg[7:1]};
    rx_shift = state_ff.order ? {state_ff.shreg[6:0], pins_in[ccs_pkg::CCS_PIN_SIN]}
      : {pins_in[ccs_pkg::CCS_PIN_SIN], state_ff.shreg[7:1]};
    nxt_state.sclk_prev = pins_in[ccs_pkg::CCS_PIN_SCLK];

    if (state_ff.phase != ccs_pkg::CCS_IDLE) begin
      if (is_master) begin
        // Eight source ticks per half period give the divide by sixteen.
        if (tick) begin
          nxt_state.div_cnt = state_ff.div_cnt + 3'h1;
          if (state_ff.div_cnt == ccs_pkg::CCS_DIV_LAST) begin
            nxt_state.sclk = ~state_ff.sclk;
            fall = state_ff.sclk;
            rise = ~state_ff.sclk;
          end
        end
      end else begin
        // The source select plays no part here.
        fall = state_ff.sclk_prev & ~pins_in[ccs_pkg::CCS_PIN_SCLK];
        rise = ~state_ff.sclk_prev & pins_in[ccs_pkg::CCS_PIN_SCLK];
      end
    end

    if (fall & is_slave) begin
      nxt_state.ready = 1'b1;
    end
    if (fall & (state_ff.phase == ccs_pkg::CCS_TX)) begin
      nxt_state.sout = out_bit;
      nxt_state.shreg = tx_shift;
    end

    // ----- Register writes; flag clears come before the sets below. -----
    if (wr_acc) begin
      if (paddr_in == ccs_pkg::CCS_OFF_CTRL) begin
        nxt_state.pin_en = pwdata_in[ccs_pkg::CCS_CTRL_PIN_EN];
        nxt_state.mode = pwdata_in[ccs_pkg::CCS_CTRL_MODE_HI:ccs_pkg::CCS_CTRL_MODE_LO];
        nxt_state.clk_src = pwdata_in[ccs_pkg::CCS_CTRL_SRC_HI:ccs_pkg::CCS_CTRL_SRC_LO];
        nxt_state.par_en = pwdata_in[ccs_pkg::CCS_CTRL_PAR_EN];
        nxt_state.order = pwdata_in[ccs_pkg::CCS_CTRL_ORDER];
        nxt_state.tx_en = pwdata_in[ccs_pkg::CCS_CTRL_TX_EN];
        nxt_state.rx_en = pwdata_in[ccs_pkg::CCS_CTRL_RX_EN];
      end else if (paddr_in == ccs_pkg::CCS_OFF_TRIG) begin
        if (pwdata_in[ccs_pkg::CCS_TRIG_TX_DONE]) begin
          nxt_state.tx_done = 1'b0;
        end
        if (pwdata_in[ccs_pkg::CCS_TRIG_RX_DONE]) begin
          nxt_state.rx_done = 1'b0;
        end
        // A trigger is refused while any transfer runs, so the line stays half duplex.
        if (sync_ok & (state_ff.phase == ccs_pkg::CCS_IDLE)) begin
          start_tx = pwdata_in[ccs_pkg::CCS_TRIG_TX] & state_ff.tx_en;
          start_rx = pwdata_in[ccs_pkg::CCS_TRIG_RX] & state_ff.rx_en & ~start_tx;
        end
      end else if (paddr_in == ccs_pkg::CCS_OFF_DATA) begin
        nxt_state.tx_byte = pwdata_in[7:0];
      end
    end

    if (rise) begin
      nxt_state.bit_cnt = state_ff.bit_cnt + 4'h1;
      case (state_ff.phase)
        ccs_pkg::CCS_TX: begin
          if (state_ff.bit_cnt == ccs_pkg::CCS_LAST_BIT) begin
            nxt_state.phase = ccs_pkg::CCS_IDLE;
            nxt_state.tx_done = 1'b1;
          end
        end
        ccs_pkg::CCS_RX: begin
          nxt_state.shreg = rx_shift;
          if (state_ff.bit_cnt == ccs_pkg::CCS_LAST_BIT) begin
            nxt_state.phase = ccs_pkg::CCS_IDLE;
            nxt_state.rx_buf = rx_shift;
            nxt_state.rx_done = 1'b1;
          end
        end
        default: begin
          nxt_state.phase = ccs_pkg::CCS_IDLE;
        end
      endcase
    end

    // Dropping the matching enable abandons the word in flight.
    if (((state_ff.phase == ccs_pkg::CCS_TX) & ~nxt_state.tx_en)
        | ((state_ff.phase == ccs_pkg::CCS_RX) & ~nxt_state.rx_en)) begin
      nxt_state.phase = ccs_pkg::CCS_IDLE;
      nxt_state.sclk = 1'b1;
      // Nothing is pending any more, so a slave must not keep claiming to be ready.
      nxt_state.ready = 1'b1;
    end

    if (start_tx | start_rx) begin
      nxt_state.phase = start_tx ? ccs_pkg::CCS_TX : ccs_pkg::CCS_RX;
      nxt_state.shreg = start_tx ? state_ff.tx_byte : 8'h00;
      nxt_state.bit_cnt = 4'h0;
      nxt_state.div_cnt = 3'h0;
      nxt_state.sclk = 1'b1;
      if (is_slave) begin
        nxt_state.ready = 1'b0;
      end
    end

    if (rd_setup) begin
      if (paddr_in == ccs_pkg::CCS_OFF_CTRL) begin
        nxt_state.prdata = {23'h000000, state_ff.rx_en, state_ff.tx_en, state_ff.order,
          state_ff.par_en, state_ff.clk_src, state_ff.mode, state_ff.pin_en};
      end else if (paddr_in == ccs_pkg::CCS_OFF_TRIG) begin
        nxt_state.prdata = {28'h0000000, state_ff.rx_done, state_ff.tx_done,
          state_ff.phase == ccs_pkg::CCS_RX, state_ff.phase == ccs_pkg::CCS_TX};
      end else if (paddr_in == ccs_pkg::CCS_OFF_DATA) begin
        nxt_state.prdata = {24'h000000, state_ff.rx_buf};
      end else begin
        nxt_state.prdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= ccs_pkg::CCS_STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------------
  // Pin multiplexing
  // ----------------------------------------------------------------------
  // The ready pin stays with the port in master mode so software can sense the slave.
  always_comb begin
    pins_out = port_in;
    if (state_ff.pin_en) begin
      pins_out.data[ccs_pkg::CCS_PIN_SIN] = 1'b0;
      pins_out.oe[ccs_pkg::CCS_PIN_SIN] = 1'b0;
      pins_out.data[ccs_pkg::CCS_PIN_SOUT] = state_ff.sout;
      pins_out.oe[ccs_pkg::CCS_PIN_SOUT] = 1'b1;
      pins_out.data[ccs_pkg::CCS_PIN_SCLK] = state_ff.sclk;
      pins_out.oe[ccs_pkg::CCS_PIN_SCLK] = is_master;
      if (is_slave) begin
        pins_out.data[ccs_pkg::CCS_PIN_SRDY] = state_ff.ready;
        pins_out.oe[ccs_pkg::CCS_PIN_SRDY] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  chk_half_duplex: assert property ((state_ff.phase == ccs_pkg::CCS_TX) |=>
    (state_ff.phase != ccs_pkg::CCS_RX)) else $error("receive began during transmit");
  chk_div_sixteen: assert property ((is_master && $changed(state_ff.sclk)
    && state_ff.phase != ccs_pkg::CCS_IDLE) |=> !$changed(state_ff.sclk)[*7])
    else $error("master shift clock half period under eight cycles");
  chk_slave_no_drive: assert property (is_slave |-> !pins_out.oe[ccs_pkg::CCS_PIN_SCLK])
    else $error("slave drives shift clock");
  chk_gpio_mode: assert property (!state_ff.pin_en |-> (pins_out == port_in))
    else $error("pins not general ports while disabled");
  chk_sout_hold: assert property ((state_ff.phase != ccs_pkg::CCS_TX) |=>
    $stable(state_ff.sout)) else $error("serial output moved while idle");
  chk_tx_done: assert property ((state_ff.phase == ccs_pkg::CCS_TX && rise
    && state_ff.bit_cnt == ccs_pkg::CCS_LAST_BIT) |=> state_ff.tx_done)
    else $error("transmit done not set after eighth bit");
  chk_rx_eighth: assert property ((state_ff.phase == ccs_pkg::CCS_RX && rise
    && state_ff.bit_cnt == ccs_pkg::CCS_LAST_BIT) |=> (state_ff.rx_done
    && state_ff.rx_buf == $past(rx_shift))) else $error("receive buffer not loaded");
  chk_ready_fall: assert property ((is_slave && (start_tx || start_rx)) |=>
    !state_ff.ready) else $error("ready not low after trigger");
  chk_ready_rise: assert property ((is_slave && fall) |=> state_ff.ready)
    else $error("ready not high after first falling edge");
  chk_trig_status: assert property ((rd_setup && paddr_in == ccs_pkg::CCS_OFF_TRIG) |=>
    (prdata_out[0] == $past(state_ff.phase == ccs_pkg::CCS_TX)))
    else $error("trigger readback not equal to busy");
  chk_rx_status: assert property ((rd_setup && paddr_in == ccs_pkg::CCS_OFF_TRIG) |=>
    (prdata_out[1] == $past(state_ff.phase == ccs_pkg::CCS_RX)))
    else $error("receive trigger readback not equal to busy");

  // An idle channel keeps the shift clock high so the far side sees no stray edge.
  chk_sclk_idle: assert property ((state_ff.phase == ccs_pkg::CCS_IDLE) |->
    state_ff.sclk) else $error("shift clock not high while idle");
  chk_bit_range: assert property ((state_ff.phase != ccs_pkg::CCS_IDLE) |->
    (state_ff.bit_cnt <= ccs_pkg::CCS_LAST_BIT)) else $error("bit count beyond one word");
  // The data line may only move one cycle after a falling edge of a transmit.
  chk_sout_on_fall: assert property ($changed(state_ff.sout) |->
    $past(fall && state_ff.phase == ccs_pkg::CCS_TX))
    else $error("serial output moved off a falling edge");
  chk_ready_idle: assert property ((state_ff.phase == ccs_pkg::CCS_IDLE) |->
    state_ff.ready) else $error("ready low with no transfer pending");
  // In master mode the ready pin belongs to the port logic.
  chk_ready_port: assert property ((state_ff.pin_en && is_master) |->
    (pins_out.oe[ccs_pkg::CCS_PIN_SRDY] == port_in.oe[ccs_pkg::CCS_PIN_SRDY])
    && (pins_out.data[ccs_pkg::CCS_PIN_SRDY] == port_in.data[ccs_pkg::CCS_PIN_SRDY]))
    else $error("ready pin taken in master mode");
  chk_sin_input: assert property (state_ff.pin_en |->
    !pins_out.oe[ccs_pkg::CCS_PIN_SIN]) else $error("serial input pin driven");

  // Done flags only fall on a write-one clear; a set in the same cycle wins.
  chk_tx_sticky: assert property ((state_ff.tx_done && !(wr_acc
    && paddr_in == ccs_pkg::CCS_OFF_TRIG && pwdata_in[ccs_pkg::CCS_TRIG_TX_DONE]))
    |=> state_ff.tx_done) else $error("transmit done dropped without a clear");
  chk_rx_sticky: assert property ((state_ff.rx_done && !(wr_acc
    && paddr_in == ccs_pkg::CCS_OFF_TRIG && pwdata_in[ccs_pkg::CCS_TRIG_RX_DONE]))
    |=> state_ff.rx_done) else $error("receive done dropped without a clear");

  cov_master_tx: cover property (is_master && state_ff.phase == ccs_pkg::CCS_TX
    ##1 state_ff.phase == ccs_pkg::CCS_IDLE);
  cov_slave_rx: cover property (is_slave && state_ff.phase == ccs_pkg::CCS_RX
    ##1 state_ff.rx_done && state_ff.phase == ccs_pkg::CCS_IDLE);
  cov_msb_first: cover property (state_ff.order && state_ff.tx_done);
  cov_both_trig: cover property (start_tx && wr_acc && pwdata_in[ccs_pkg::CCS_TRIG_RX]);
  cov_abort: cover property (state_ff.phase == ccs_pkg::CCS_TX
    ##1 state_ff.phase == ccs_pkg::CCS_IDLE && !state_ff.tx_done);
endmodule : ccs_core

// ### core/ccs_pkg.sv
/*
  Shared constants and types for the clock-synchronous serial transfer block.
  Assumes a 32-bit APB master and a 12-bit byte address.
*/
package ccs_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] CCS_OFF_CTRL = 12'h000;
  localparam logic [11:0] CCS_OFF_TRIG = 12'h004;
  localparam logic [11:0] CCS_OFF_DATA = 12'h008;

  localparam int CCS_CTRL_PIN_EN = 0;
  localparam int CCS_CTRL_MODE_LO = 1;
  localparam int CCS_CTRL_MODE_HI = 2;
  localparam int CCS_CTRL_SRC_LO = 3;
  localparam int CCS_CTRL_SRC_HI = 4;
  localparam int CCS_CTRL_PAR_EN = 5;
  localparam int CCS_CTRL_ORDER = 6;
  localparam int CCS_CTRL_TX_EN = 7;
  localparam int CCS_CTRL_RX_EN = 8;

  localparam int CCS_TRIG_TX = 0;
  localparam int CCS_TRIG_RX = 1;
  localparam int CCS_TRIG_TX_DONE = 2;
  localparam int CCS_TRIG_RX_DONE = 3;

  // ----------------------------------------------------------------------
  // Pins, modes and counts
  // ----------------------------------------------------------------------
  localparam int CCS_PIN_SIN = 0;
  localparam int CCS_PIN_SOUT = 1;
  localparam int CCS_PIN_SCLK = 2;
  localparam int CCS_PIN_SRDY = 3;

  localparam logic [1:0] CCS_MODE_MASTER = 2'h0;
  localparam logic [1:0] CCS_MODE_SLAVE = 2'h1;
  localparam logic [2:0] CCS_DIV_LAST = 3'h7;
  localparam logic [3:0] CCS_LAST_BIT = 4'h7;

  typedef enum logic [1:0] {
    CCS_IDLE = 2'b00,
    CCS_TX = 2'b01,
    CCS_RX = 2'b10
  } ccs_phase_t;

  typedef struct packed {
    logic [3:0] data;
    logic [3:0] oe;
  } ccs_pins_t;

  typedef struct packed {
    logic pin_en;
    logic [1:0] mode;
    logic [1:0] clk_src;
    logic par_en;
    logic order;
    logic tx_en;
    logic rx_en;
    logic [7:0] tx_byte;
    logic [7:0] rx_buf;
    logic [7:0] shreg;
    logic [3:0] bit_cnt;
    logic [2:0] div_cnt;
    ccs_phase_t phase;
    logic tx_done;
    logic rx_done;
    logic sclk;
    logic sclk_prev;
    logic ready;
    logic sout;
    logic [31:0] prdata;
  } ccs_state_t;

  localparam ccs_state_t CCS_STATE_RST = '{
    phase: CCS_IDLE,
    sclk: 1'b1,
    sclk_prev: 1'b1,
    ready: 1'b1,
    sout: 1'b1,
    default: '0
  };
endpackage : ccs_pkg

// ### dv/ccs_far_model.sv
/*
  Far-side serial device: takes the data line on rising shift-clock edges and
  shows its own byte on falling ones; on request it also makes the shift clock.
  Assumes the bench resolves the pin levels.
*/
`timescale 1ns/1ps
module ccs_far_model (
  input wire logic clock_in,
  input wire logic drive_clk_in,
  input wire logic go_in,
  input wire logic [7:0] byte_in,
  input wire logic sclk_in,
  input wire logic sout_in,
  output logic sclk_out,
  output logic sin_out,
  output logic [7:0] got_out
);
  // --------------------------------------------------------------
  // Line behaviour
  // --------------------------------------------------------------
  logic prev = 1'b1;
  logic idle = 1'b1;
  logic [3:0] idx = 4'h8;
  logic [1:0] half = 2'h0;
  logic [4:0] edges = 5'h00;
  initial begin
    sclk_out = 1'b1;
    sin_out = 1'b0;
    got_out = 8'h00;
  end
  always @(posedge clock_in) begin
    prev <= sclk_in;
    half <= half + 2'h1;
    if (go_in) begin
      idx <= 4'h0;
      idle <= 1'b0;
      half <= 2'h0;
      edges <= drive_clk_in ? 5'h10 : 5'h00;
    end else if (edges != 5'h00 && half == 2'h3) begin
      // The clock stands high between frames and runs for one word only.
      sclk_out <= ~sclk_out;
      edges <= edges - 5'h01;
    end
    if (prev && !sclk_in && idx < 4'h8) begin
      sin_out <= byte_in[idx[2:0]];
      idx <= idx + 4'h1;
    end else if (idle) begin
      // A released data line must not look like a held last bit.
      sin_out <= ~sin_out;
    end
    if (!prev && sclk_in) begin
      got_out <= {sout_in, got_out[7:1]};
      idle <= (idx == 4'h8);
    end
  end
endmodule : ccs_far_model

// ### dv/clock_sync_serial_transfer_test.sv
/*
  Self-checking bench: a table of transfers, then reset, refusal and abort cases.
  Assumes the far side is the behavioural model and pins resolve here.
*/
`timescale 1ns/1ps
module clock_sync_serial_transfer_test;
  // --------------------------------------------------------------
  // Wiring and clock
  // --------------------------------------------------------------
  typedef struct packed {
    logic slave;
    logic order;
    logic rx;
    logic par;
    logic [1:0] src;
    logic [7:0] dat;
  } ccs_row_t;
  localparam ccs_row_t ROWS [8] = '{
    '{1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 8'hA5}, '{1'b0, 1'b1, 1'b0, 1'b1, 2'h1, 8'h3C},
    '{1'b0, 1'b0, 1'b1, 1'b0, 2'h2, 8'h96}, '{1'b0, 1'b1, 1'b1, 1'b0, 2'h3, 8'h0F},
    '{1'b1, 1'b0, 1'b0, 1'b0, 2'h2, 8'hC1}, '{1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 8'h81},
    '{1'b1, 1'b0, 1'b1, 1'b1, 2'h1, 8'h7E}, '{1'b1, 1'b1, 1'b1, 1'b0, 2'h3, 8'h52}};
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic err;
  logic [31:0] q;
  logic [31:0] c;
  logic [3:0] tick = 4'h0;
  logic [3:0] pins;
  logic sclk_q = 1'b1;
  logic drv = 1'b0;
  logic go = 1'b0;
  logic [7:0] pbyte = 8'h00;
  logic p_sclk;
  logic p_sin;
  logic [7:0] p_got;
  ccs_pkg::ccs_pins_t port = 8'h5A;
  ccs_pkg::ccs_pins_t pout;
  ccs_row_t r;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int last_fall = 0;
  int period = 0;
  assign pins = {pout.oe[3] ? pout.data[3] : 1'b1, pout.oe[2] ? pout.data[2] : p_sclk,
                 pout.oe[1] ? pout.data[1] : 1'b1, p_sin};
  ccs_core u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .clk_src_tick_in(tick), .pins_in(pins), .port_in(port), .pins_out(pout));
  ccs_far_model u_far (.clock_in(clock_in), .drive_clk_in(drv), .go_in(go),
    .byte_in(pbyte), .sclk_in(pins[2]), .sout_in(pins[1]), .sclk_out(p_sclk),
    .sin_out(p_sin), .got_out(p_got));
  initial begin
    forever #2 clock_in = ~clock_in;
  end
  // Source k ticks every k+1 cycles, so each source gives its own shift-clock period.
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    for (int k = 0; k < 4; k++) tick[k] <= (((cyc + 1) % (k + 1)) == 0);
    sclk_q <= pins[2];
    if (pout.oe[2] && sclk_q && !pins[2]) begin
      period <= cyc - last_fall;
      last_fall <= cyc;
    end
  end
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge clock_in);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic kick();
    @(posedge clock_in);
    go <= 1'b1;
    @(posedge clock_in);
    go <= 1'b0;
  endtask : kick
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    q = 32'h0;
    while (q[b] !== 1'b1 && n < 400) begin
      apb(1'b0, ccs_pkg::CCS_OFF_TRIG, 32'h0);
      n++;
    end
    if (q[b] !== 1'b1) begin
      fail_count++;
      $display("MISMATCH flag_wait expected 1 seen %b", q[b]);
    end
  endtask : wait_flag
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev8[k] = v[7 - k];
  endfunction : rev8
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (50000) @(posedge clock_in);
    fail_count++;
    end_sim();
  end
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock_in);
    chk("pins_reset", 32'h5A, 32'(pout));
    reset_n_in <= 1'b1;
    apb(1'b0, ccs_pkg::CCS_OFF_TRIG, 32'h0);
    chk("trig_reset", 32'h0, q);
    apb(1'b1, ccs_pkg::CCS_OFF_CTRL, 32'h3);
    @(posedge clock_in);
    chk("ready_reset", 32'h3, {pout.oe[3], pout.data[3]});
    foreach (ROWS[i]) begin
      r = ROWS[i];
      drv <= r.slave;
      pbyte <= r.dat;
      c = {23'h0, r.rx, !r.rx, r.order, r.par, r.src, 1'b0, r.slave, 1'b1};
      apb(1'b1, ccs_pkg::CCS_OFF_CTRL, c & 32'h0000007F);
      apb(1'b1, ccs_pkg::CCS_OFF_CTRL, c);
      if (!r.slave) chk("ready_port", {port.oe[3], port.data[3]}, {pout.oe[3], pout.data[3]});
      apb(1'b1, ccs_pkg::CCS_OFF_DATA, {24'h0, r.dat});
      if (!r.slave) kick();
      apb(1'b1, ccs_pkg::CCS_OFF_TRIG, r.rx ? 32'h2 : 32'h1);
      apb(1'b0, ccs_pkg::CCS_OFF_TRIG, 32'h0);
      chk("busy", 32'h1, q[r.rx]);
      if (r.slave) chk("ready_low", 32'h2, {pout.oe[3], pout.data[3]});
      if (r.slave) kick();
      wait_flag(r.rx ? 3 : 2);
      apb(1'b0, ccs_pkg::CCS_OFF_TRIG, 32'h0);
      chk("flags", r.rx ? 32'h8 : 32'h4, q);
      if (r.rx) begin
        apb(1'b0, ccs_pkg::CCS_OFF_DATA, 32'h0);
        chk("rx_word", r.order ? rev8(r.dat) : r.dat, q[7:0]);
      end else begin
        chk("tx_word", r.order ? rev8(r.dat) : r.dat, p_got);
        chk("sout_hold", r.order ? r.dat[0] : r.dat[7], pout.data[1]);
      end
      if (r.slave) chk("ready_busy", 32'h3, {pout.oe[3], pout.data[3]});
      else chk("period", 32'(16 * (r.src + 1)), period);
      apb(1'b1, ccs_pkg::CCS_OFF_TRIG, r.rx ? 32'h8 : 32'h4);
    end
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped_err", 32'h1, err);
    chk("unmapped_data", 32'h0, q);
    drv <= 1'b0;
    apb(1'b1, ccs_pkg::CCS_OFF_CTRL, 32'h181);
    apb(1'b1, ccs_pkg::CCS_OFF_TRIG, 32'h3);
    apb(1'b1, ccs_pkg::CCS_OFF_TRIG, 32'h2);
    apb(1'b0, ccs_pkg::CCS_OFF_TRIG, 32'h0);
    chk("rx_refused", 32'h1, q);
    wait_flag(2);
    apb(1'b0, ccs_pkg::CCS_OFF_TRIG, 32'h0);
    chk("both_trig", 32'h4, q);
    apb(1'b1, ccs_pkg::CCS_OFF_TRIG, 32'h4);
    apb(1'b1, ccs_pkg::CCS_OFF_TRIG, 32'h1);
    apb(1'b1, ccs_pkg::CCS_OFF_CTRL, 32'h101);
    apb(1'b0, ccs_pkg::CCS_OFF_TRIG, 32'h0);
    chk("abort", 32'h0, q);
    apb(1'b1, ccs_pkg::CCS_OFF_TRIG, 32'h1);
    apb(1'b0, ccs_pkg::CCS_OFF_TRIG, 32'h0);
    chk("refused", 32'h0, q);
    apb(1'b1, ccs_pkg::CCS_OFF_CTRL, 32'h185);
    apb(1'b1, ccs_pkg::CCS_OFF_TRIG, 32'h1);
    apb(1'b0, ccs_pkg::CCS_OFF_TRIG, 32'h0);
    chk("mode_refused", 32'h0, q);
    // A second reset in mid-run must drop every setting again.
    reset_n_in <= 1'b0;
    @(posedge clock_in);
    chk("pins_mid_reset", 32'h5A, 32'(pout));
    reset_n_in <= 1'b1;
    apb(1'b0, ccs_pkg::CCS_OFF_CTRL, 32'h0);
    chk("ctrl_mid_reset", 32'h0, q);
    end_sim();
  end
endmodule : clock_sync_serial_transfer_test
